// ===== rtl/sahc_pkg.sv
package sahc_pkg;
  // Result format
  localparam int SAHC_RES_W = 10;
  localparam int SAHC_BYTE_W = 8;
  localparam int SAHC_HI_W = 2;
  // Conversion length after the strobe, in conversion clock periods
  localparam int SAHC_CONV_CLKS = 46;
  localparam logic [5:0] SAHC_CONV_CNT = 6'(SAHC_CONV_CLKS);
  // Pin-to-logic delay of the strobe path, taken out of the conversion count
  localparam int SAHC_SYNC_LAT = 3;
  localparam logic [5:0] SAHC_CONV_LOAD = 6'(SAHC_CONV_CLKS - SAHC_SYNC_LAT);
  // Recommended minimum strobe spacing for the host
  localparam int SAHC_MIN_SPACING_CLKS = 50;
  localparam int SAHC_SPACING_MULT = 4;
  // Byte-format address map (address bit 0)
  localparam logic SAHC_ADDR_LO = 1'b0;
  localparam logic SAHC_ADDR_HI = 1'b1;
  // Status flag position on the data bus in the high-byte read
  localparam int SAHC_EOC_BIT = 7;
  // Reset values
  localparam logic [SAHC_RES_W-1:0] SAHC_RES_RST = 10'h000;
  localparam logic [5:0] SAHC_CNT_RST = 6'h00;
  typedef enum logic [1:0] {SAHC_IDLE, SAHC_STROBE, SAHC_CONV} sahc_state_e;
endpackage

// ===== rtl/sahc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module sahc_sync
  import sahc_pkg::*;
#(
  parameter int WIDTH = 1
) (
  // Clock, reset and enable
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // Data
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta;
  // Pins idle high (strobes inactive), so reset to all ones
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      meta <= '1;
      o_sync <= '1;
    end else if (i_ce) begin
      meta <= i_async;
      o_sync <= meta;
    end
  end
endmodule // sahc_sync
`default_nettype wire

// ===== rtl/sahc_top.sv
`timescale 1ns/1ps
`default_nettype none
module sahc_top
  import sahc_pkg::*;
#(
  parameter bit BYTE_FORMAT = 1'b0
) (
  // Clock, reset, enable
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // Host bus pins
  input wire logic i_cs_n,
  input wire logic i_rd_n,
  input wire logic i_wr_n,
  input wire logic i_addr,
  output logic [SAHC_RES_W-1:0] o_data,
  output logic [SAHC_RES_W-1:0] o_data_oe,
  output logic o_rdy_oe,
  output logic o_int_oe,
  // Successive-approximation core
  input wire logic i_cmp,
  output logic o_sample,
  output logic [SAHC_RES_W-1:0] o_dac
);
  // Host pins after the synchronizer
  logic cs_n_s;
  logic rd_n_s;
  logic wr_n_s;
  logic addr_s;
  // Strobe level one period back, for edge detection
  logic wr_n_d;
  // Conversion sequencing
  sahc_state_e state;
  sahc_state_e next_state;
  logic [5:0] cnt;
  logic [5:0] next_cnt;
  // Approximation register and the trial code for the analog core
  logic [SAHC_RES_W-1:0] sar;
  logic [SAHC_RES_W-1:0] next_sar;
  logic [SAHC_RES_W-1:0] next_dac;
  // Result and completion flags
  logic [SAHC_RES_W-1:0] result;
  logic eoc;
  logic int_pend;
  // Read path
  wire [SAHC_RES_W-1:0] oe_mask;
  logic [SAHC_RES_W-1:0] next_data;

  // Weight of the bit under trial
  function automatic logic [SAHC_RES_W-1:0] sahc_trial(input logic [3:0] idx);
    sahc_trial = SAHC_RES_W'(1) << idx;
  endfunction

  // The last ten periods of the count each decide one bit, MSB first
  function automatic logic sahc_in_bits(input sahc_state_e st, input logic [5:0] count);
    sahc_in_bits = (st == SAHC_CONV) && (count <= 6'(SAHC_RES_W)) && (count != 6'h00);
  endfunction

  sahc_sync #(.WIDTH(4)) u_sync (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_async({i_cs_n, i_rd_n, i_wr_n, i_addr}),
    .o_sync({cs_n_s, rd_n_s, wr_n_s, addr_s})
  );

  // Strobes only count while chip select is low
  wire wr_act = !cs_n_s && !wr_n_s;
  wire rd_act = !cs_n_s && !rd_n_s;
  wire wr_fall = wr_act && wr_n_d;
  // A write that lands during a conversion is ignored rather than restarting it
  wire conv_start = wr_fall && (state == SAHC_IDLE);

  wire bit_phase = sahc_in_bits(state, cnt);
  wire [3:0] bit_idx = 4'(cnt - 6'h01);
  wire trial_hit = bit_phase && i_cmp;
  wire conv_done = (state == SAHC_CONV) && (cnt == 6'h01);

  always_comb begin
    next_state = state;
    case (state)
      SAHC_IDLE: begin
        if (conv_start) begin
          next_state = SAHC_STROBE;
        end
      end
      SAHC_STROBE: begin
        if (!wr_act) begin
          next_state = SAHC_CONV;
        end
      end
      SAHC_CONV: begin
        if (conv_done) begin
          next_state = SAHC_IDLE;
        end
      end
      default: begin
        next_state = SAHC_IDLE;
      end
    endcase
  end

  // The count is loaded short by the synchronizer delay, so the deadline holds at the pins
  always_comb begin
    next_cnt = cnt;
    case (state)
      SAHC_STROBE: begin
        next_cnt = SAHC_CONV_LOAD;
      end
      SAHC_CONV: begin
        next_cnt = cnt - 6'h01;
      end
      default: begin
        next_cnt = cnt;
      end
    endcase
  end

  // Sampling is held for the whole strobe; conversion timing starts at its release
  assign o_sample = (state == SAHC_STROBE);

  // Keep the trial bit when the comparator reports the input above the trial code
  wire [SAHC_RES_W-1:0] kept_sar = trial_hit ? (sar | sahc_trial(bit_idx)) : sar;
  assign next_sar = (state == SAHC_STROBE) ? SAHC_RES_RST : kept_sar;

  // Trial code for the next period, so the DAC word comes straight from a flop
  wire next_bit_phase = sahc_in_bits(next_state, next_cnt);
  wire [3:0] next_bit_idx = 4'(next_cnt - 6'h01);
  assign next_dac = next_bit_phase ? (next_sar | sahc_trial(next_bit_idx)) : next_sar;

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_n_d <= 1'b1;
      state <= SAHC_IDLE;
      cnt <= SAHC_CNT_RST;
    end else if (i_ce) begin
      wr_n_d <= !wr_act;
      state <= next_state;
      cnt <= next_cnt;
    end
  end

  // A registered trial word keeps the comparator input settled for a whole period
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      sar <= SAHC_RES_RST;
      o_dac <= SAHC_RES_RST;
    end else if (i_ce) begin
      sar <= next_sar;
      o_dac <= next_dac;
    end
  end

  // The result takes the final bit decided in the last period
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      result <= SAHC_RES_RST;
    end else if (i_ce) begin
      if (conv_done) begin
        result <= next_sar;
      end
    end
  end

  // Status flag: completion wins over a start in the same period
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      eoc <= 1'b0;
    end else if (i_ce) begin
      if (conv_done) begin
        eoc <= 1'b1;
      end else if (conv_start) begin
        eoc <= 1'b0;
      end
    end
  end

  // Interrupt: completion wins; otherwise a new start or any read clears it
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      int_pend <= 1'b0;
    end else if (i_ce) begin
      if (conv_done) begin
        int_pend <= 1'b1;
      end else if (conv_start || rd_act) begin
        int_pend <= 1'b0;
      end
    end
  end

  // Read mux: word format is one read; byte format splits by address
  wire [SAHC_RES_W-1:0] word_data = result;
  wire [SAHC_RES_W-1:0] hi_data = {2'b00, eoc, 5'h00, result[SAHC_RES_W-1 -: SAHC_HI_W]};
  wire [SAHC_RES_W-1:0] lo_data = {2'b00, result[SAHC_BYTE_W-1:0]};
  assign next_data = !BYTE_FORMAT ? word_data : ((addr_s == SAHC_ADDR_HI) ? hi_data : lo_data);

  // Byte format never drives the two top data lines
  for (genvar g = 0; g < SAHC_RES_W; g++) begin : g_oe_mask
    assign oe_mask[g] = !BYTE_FORMAT || (g < SAHC_BYTE_W);
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_data <= SAHC_RES_RST;
      o_data_oe <= SAHC_RES_RST;
    end else if (i_ce) begin
      o_data <= next_data;
      o_data_oe <= rd_act ? oe_mask : SAHC_RES_RST;
    end
  end

  // Open-drain: enable high pulls the pin low
  assign o_int_oe = int_pend;
  // Busy spans strobe and conversion, and only shows while the host selects the device
  wire conv_busy = (state != SAHC_IDLE) || wr_act;
  assign o_rdy_oe = !cs_n_s && !eoc && conv_busy;
endmodule // sahc_top
`default_nettype wire

// ===== sim/sahc_cmp_model.sv
`timescale 1ns/1ps
`default_nettype none
module sahc_cmp_model (
  input wire logic [9:0] i_level,
  input wire logic [9:0] i_dac,
  output logic o_cmp
);
  // Input sits half an LSB above its code, so a trial never ties
  assign o_cmp = (i_dac <= i_level);
endmodule // sahc_cmp_model
`default_nettype wire

// ===== sim/sahc_top_chk.sv
`timescale 1ns/1ps
`default_nettype none
module sahc_top_chk #(
  parameter bit BYTE_FORMAT = 1'b0
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_cs_n,
  input wire logic i_rd_n,
  input wire logic i_wr_n,
  input wire logic [9:0] o_data_oe,
  input wire logic o_rdy_oe,
  input wire logic o_int_oe,
  input wire logic o_sample
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  property p_start; $fell(i_wr_n) && !i_cs_n && !o_rdy_oe |-> ##[1:4] o_sample; endproperty
  a_start: assert property (p_start) else $error("no sampling");
  property p_busy; $rose(o_sample) |-> o_rdy_oe; endproperty
  a_busy: assert property (p_busy) else $error("not busy");
  property p_time; $fell(o_sample) |-> ##[30:52] o_int_oe; endproperty
  a_time: assert property (p_time) else $error("late end");
  property p_early; $fell(o_sample) |-> !o_int_oe [*8]; endproperty
  a_early: assert property (p_early) else $error("early end");
  property p_done; $rose(o_int_oe) |-> ##[0:1] !o_rdy_oe; endproperty
  a_done: assert property (p_done) else $error("busy at end");
  property p_float; i_cs_n [*5] |-> o_data_oe == 10'h000; endproperty
  a_float: assert property (p_float) else $error("bus driven");
  property p_read; (!i_cs_n && !i_rd_n) [*4] |-> o_data_oe == (BYTE_FORMAT ? 10'h0FF : 10'h3FF); endproperty
  a_read: assert property (p_read) else $error("bus idle");
  property p_hold; i_cs_n [*4] ##0 o_int_oe |=> o_int_oe; endproperty
  a_hold: assert property (p_hold) else $error("flag lost");
  c_conv: cover property ($fell(o_sample));
  c_int: cover property ($rose(o_int_oe));
  c_read: cover property (o_data_oe != 10'h000);
endmodule // sahc_top_chk
bind sahc_top sahc_top_chk #(.BYTE_FORMAT(BYTE_FORMAT)) u_sahc_top_chk (.i_core_clk(i_core_clk), .i_rst(i_rst),
  .i_cs_n(i_cs_n), .i_rd_n(i_rd_n), .i_wr_n(i_wr_n), .o_data_oe(o_data_oe), .o_rdy_oe(o_rdy_oe),
  .o_int_oe(o_int_oe), .o_sample(o_sample));
`default_nettype wire

// ===== sim/sampling_adc_host_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
module sampling_adc_host_control_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cs_n = 1'b1;
  logic rd_n = 1'b1;
  logic wr_n = 1'b1;
  logic addr = 1'b0;
  logic [9:0] level = 10'h000;
  logic [9:0] data, oe, dac;
  logic rdy, intr, sample, cmp;
  logic [9:0] data_b, oe_b, dac_b;
  logic rdy_b, intr_b, sample_b, cmp_b;
  int mismatches = 0;
  int samples_checked = 0;
  always #4 clk = ~clk;
  sahc_top u_sahc_top (.i_core_clk(clk), .i_rst(rst), .i_ce(1'b1), .i_cs_n(cs_n), .i_rd_n(rd_n),
    .i_wr_n(wr_n), .i_addr(addr), .o_data(data), .o_data_oe(oe), .o_rdy_oe(rdy), .o_int_oe(intr),
    .i_cmp(cmp), .o_sample(sample), .o_dac(dac));
  sahc_cmp_model u_sahc_cmp_model (.i_level(level), .i_dac(dac), .o_cmp(cmp));
  // Byte-format variant on the same host pins
  sahc_top #(.BYTE_FORMAT(1'b1)) u_sahc_top_byte (.i_core_clk(clk), .i_rst(rst), .i_ce(1'b1), .i_cs_n(cs_n),
    .i_rd_n(rd_n), .i_wr_n(wr_n), .i_addr(addr), .o_data(data_b), .o_data_oe(oe_b), .o_rdy_oe(rdy_b),
    .o_int_oe(intr_b), .i_cmp(cmp_b), .o_sample(sample_b), .o_dac(dac_b));
  sahc_cmp_model u_sahc_cmp_model_byte (.i_level(level), .i_dac(dac_b), .o_cmp(cmp_b));
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // One 68-clock frame: strobe, busy poll, wait, word and byte reads; spacing stays a multiple of four
  task automatic t_convert(input logic [9:0] v);
    level = v;
    cs_n = 1'b0;
    wr_n = 1'b0;
    cyc(4);
    chk({8'h00, sample, sample_b}, 10'h003);
    cs_n = 1'b1;
    wr_n = 1'b1;
    cyc(8);
    addr = 1'b1;
    cs_n = 1'b0;
    rd_n = 1'b0;
    cyc(4);
    chk({8'h00, rdy, rdy_b}, 10'h003);
    chk({9'h000, data_b[7]}, 10'h000);
    cs_n = 1'b1;
    rd_n = 1'b1;
    cyc(34);
    chk({8'h00, intr, intr_b}, 10'h003);
    cyc(2);
    addr = 1'b0;
    cs_n = 1'b0;
    rd_n = 1'b0;
    cyc(4);
    chk(data, v);
    chk(oe, 10'h3FF);
    chk(data_b, {2'b00, v[7:0]});
    chk(oe_b, 10'h0FF);
    chk({8'h00, rdy, rdy_b}, 10'h000);
    cs_n = 1'b1;
    rd_n = 1'b1;
    cyc(4);
    chk(oe, 10'h000);
    chk({8'h00, intr, intr_b}, 10'h000);
    addr = 1'b1;
    cs_n = 1'b0;
    rd_n = 1'b0;
    cyc(4);
    chk(data_b, {2'b00, 1'b1, 5'h00, v[9:8]});
    cs_n = 1'b1;
    rd_n = 1'b1;
    cyc(4);
    chk(oe_b, 10'h000);
    $display("convert %h done", v);
  endtask
  task automatic t_ignored;
    wr_n = 1'b0;
    cyc(4);
    chk({8'h00, sample, sample_b}, 10'h000);
    wr_n = 1'b1;
    cyc(60);
    chk({8'h00, intr, intr_b}, 10'h000);
    $display("deselected write done");
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    cyc(4);
    rst = 1'b0;
    cyc(3);
    t_convert(10'h000);
    t_convert(10'h3FF);
    t_convert(10'h155);
    t_ignored();
    t_convert(10'h2AA);
    t_convert(10'h200);
    results();
  end
  // Six frames take about 3.3 us; allow plenty more
  initial begin
    #20000;
    mismatches++;
    results();
  end
endmodule // sampling_adc_host_control_bench
`default_nettype wire
